// *** shared/cec_pkg.sv ***
// Constants for the correctable error counter bank
package cec_pkg;
   // Register addresses in the control/status space
   localparam logic [11:0] CEC_ADDR_ICACHE = 12'h7F0;
   localparam logic [11:0] CEC_ADDR_ITCM   = 12'h7F1;
   localparam logic [11:0] CEC_ADDR_DTCM   = 12'h7F2;
   localparam int          CEC_ADDR_W      = 12;
   // Field layout of each counter register
   localparam int          CEC_DATA_W      = 32;
   localparam int          CEC_THRESH_MSB  = 31;
   localparam int          CEC_THRESH_LSB  = 27;
   localparam int          CEC_THRESH_W    = 5;
   localparam int          CEC_COUNT_MSB   = 26;
   localparam int          CEC_COUNT_W     = 27;
   // Largest legal threshold selector
   localparam logic [4:0]  CEC_THRESH_MAX  = 5'h1A;
   // Reset values of the fields
   localparam logic [4:0]  CEC_THRESH_RST  = 5'h00;
   localparam logic [26:0] CEC_COUNT_RST   = 27'h0000000;
   localparam logic [31:0] CEC_RDATA_RST   = 32'h00000000;
   // Counter channels and cache ways feeding the first one
   localparam int          CEC_CHANNELS    = 3;
   localparam int          CEC_CH_ICACHE   = 0;
   localparam int          CEC_CH_ITCM     = 1;
   localparam int          CEC_CH_DTCM     = 2;
   localparam int          CEC_IC_WAYS     = 4;
   localparam int          CEC_INC_W       = 2;
endpackage : cec_pkg

// *** design/cec_counter.sv ***
// One counter/threshold register with its pending-threshold condition
module cec_counter (
   input  wire logic        clk,
   input  wire logic        rst,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   input  wire logic [1:0]  inc,
   output logic      [31:0] reg_val,
   output logic             pending
);
   logic [4:0]  thresh_q;   // Threshold bit selector
   logic [4:0]  thresh_d;
   logic [26:0] count_q;    // Error count, wraps on overflow
   logic [26:0] count_d;
   logic [4:0]  wr_thresh;  // Selector field of the write data

   assign wr_thresh = wr_data[cec_pkg::CEC_THRESH_MSB:cec_pkg::CEC_THRESH_LSB];

   // Next values: a software write replaces both fields and wins over a
   // same-cycle increment, so firmware can reliably reset the count
   always_comb begin
      thresh_d = thresh_q;
      count_d  = count_q;
      if (wr_en) begin
         // Illegal selectors fold onto the top count bit
         if (wr_thresh > cec_pkg::CEC_THRESH_MAX) begin
            thresh_d = cec_pkg::CEC_THRESH_MAX;
         end else begin
            thresh_d = wr_thresh;
         end
         count_d = wr_data[cec_pkg::CEC_COUNT_MSB:0];
      end else begin
         // No saturation: the sum simply wraps at 27 bits
         count_d = count_q + cec_pkg::CEC_COUNT_W'(inc);
      end
   end

   // Register stage
   always_ff @(posedge clk) begin
      if (rst) begin
         thresh_q <= cec_pkg::CEC_THRESH_RST;
         count_q  <= cec_pkg::CEC_COUNT_RST;
      end else begin
         thresh_q <= thresh_d;
         count_q  <= count_d;
      end
   end

   assign reg_val = {thresh_q, count_q};
   // Pending while count >= 2**thresh; not sticky, so a wrap or a
   // firmware reset of the count ends it
   assign pending = |(count_q >> thresh_q);

   default clocking cb @(posedge clk); endclocking
   default disable iff (rst);

   thresh_clamp_a:
   assert property (wr_en && wr_thresh > 5'h1A |=> thresh_q == 5'h1A)
      else $error("illegal threshold not folded to 26");

   write_load_a:
   assert property (wr_en |=> count_q == $past(wr_data[26:0]))
      else $error("write did not load count");

   read_hold_a:
   assert property (!wr_en && inc == 2'h0 |=> $stable(reg_val))
      else $error("register changed without write or error");

   inc_step_a:
   assert property (!wr_en && inc == 2'h1
                    |=> count_q == 27'($past(count_q) + 27'h1))
      else $error("count did not step by one");

   wrap_zero_a:
   assert property (!wr_en && inc == 2'h1 && count_q == 27'h7FFFFFF
                    |=> count_q == 27'h0 && !pending)
      else $error("count did not wrap to zero");

   rise_pend_a:
   assert property ($rose(count_q[thresh_q]) |-> pending)
      else $error("threshold crossing not pending");
endmodule : cec_counter

// *** design/cec_top.sv ***
// Correctable memory error counter/threshold register bank
module cec_top (
   input  wire logic        REF_CLK,
   input  wire logic        RESET,
   // Control/status register access port
   input  wire logic        CSR_RD_EN,
   input  wire logic        CSR_WR_EN,
   input  wire logic [11:0] CSR_ADDR,
   input  wire logic [31:0] CSR_WDATA,
   output logic      [31:0] CSR_RDATA,
   output logic             CSR_RVALID,
   // Instruction cache detectors, one tag flag per way
   input  wire logic [3:0]  IC_TAG_ERR,
   input  wire logic        IC_DATA_ERR,
   // Instruction tightly coupled memory single-bit errors
   input  wire logic        ITCM_FETCH_ERR,
   input  wire logic        ITCM_DMA_ERR,
   // Data tightly coupled memory single-bit errors
   input  wire logic        DTCM_LS_ERR,
   input  wire logic        DTCM_LS_RETIRE,
   input  wire logic        DTCM_LS_SPEC,
   input  wire logic        DTCM_LS_EXC,
   input  wire logic        DTCM_DMA_ERR,
   // Correctable error local interrupt, level
   output logic             CORR_ERR_INT
);
   // Per-channel write strobes, increments and register images
   logic [2:0]  wr_sel;
   logic [1:0]  inc     [3];
   logic [31:0] reg_val [3];
   logic [2:0]  pending;
   logic        ic_any;       // Any cache error this cycle
   logic        dtcm_ls_ok;   // Data access qualifies for counting
   logic [31:0] rdata_d;      // Read data next value
   logic [31:0] rdata_q;
   logic        rvalid_d;
   logic        rvalid_q;
   logic        int_d;        // Interrupt next value
   logic        int_q;

   // Write decode; unmapped addresses are silently ignored
   always_comb begin
      wr_sel = 3'h0;
      if (!CSR_WR_EN) begin
         wr_sel = 3'h0;
      end else if (CSR_ADDR == cec_pkg::CEC_ADDR_ICACHE) begin
         wr_sel[cec_pkg::CEC_CH_ICACHE] = 1'b1;
      end else if (CSR_ADDR == cec_pkg::CEC_ADDR_ITCM) begin
         wr_sel[cec_pkg::CEC_CH_ITCM] = 1'b1;
      end else if (CSR_ADDR == cec_pkg::CEC_ADDR_DTCM) begin
         wr_sel[cec_pkg::CEC_CH_DTCM] = 1'b1;
      end
   end

   // Event qualification: only counts leave this block, never the
   // address of the failing access
   always_comb begin
      // Several cache errors in one cycle merge into one step
      ic_any = (|IC_TAG_ERR) | IC_DATA_ERR;
      inc[cec_pkg::CEC_CH_ICACHE] = {1'b0, ic_any};
      // Fetch and DMA errors are separate events, so both can count
      inc[cec_pkg::CEC_CH_ITCM] =
         2'(ITCM_FETCH_ERR) + 2'(ITCM_DMA_ERR);
      // Speculative or faulting accesses never reach the counter
      dtcm_ls_ok = DTCM_LS_ERR & DTCM_LS_RETIRE
                   & ~DTCM_LS_SPEC & ~DTCM_LS_EXC;
      // DMA path is not gated by sleep or debug halt
      inc[cec_pkg::CEC_CH_DTCM] =
         2'(dtcm_ls_ok) + 2'(DTCM_DMA_ERR);
   end

   // The three counter registers
   generate
      for (genvar ch = 0; ch < cec_pkg::CEC_CHANNELS; ch++) begin : g_ch
         cec_counter u_cnt (
            .clk     (REF_CLK),
            .rst     (RESET),
            .wr_en   (wr_sel[ch]),
            .wr_data (CSR_WDATA),
            .inc     (inc[ch]),
            .reg_val (reg_val[ch]),
            .pending (pending[ch])
         );
      end
   endgenerate

   // Read decode; reads have no side effect, unmapped reads give zero
   always_comb begin
      rdata_d  = cec_pkg::CEC_RDATA_RST;
      rvalid_d = CSR_RD_EN;
      if (!CSR_RD_EN) begin
         rdata_d = cec_pkg::CEC_RDATA_RST;
      end else if (CSR_ADDR == cec_pkg::CEC_ADDR_ICACHE) begin
         rdata_d = reg_val[cec_pkg::CEC_CH_ICACHE];
      end else if (CSR_ADDR == cec_pkg::CEC_ADDR_ITCM) begin
         rdata_d = reg_val[cec_pkg::CEC_CH_ITCM];
      end else if (CSR_ADDR == cec_pkg::CEC_ADDR_DTCM) begin
         rdata_d = reg_val[cec_pkg::CEC_CH_DTCM];
      end
   end

   // Any pending channel raises the shared interrupt; it follows the
   // counters with one cycle of lag so the output comes from a flop
   always_comb begin
      int_d = |pending;
   end

   // Output registers
   always_ff @(posedge REF_CLK) begin
      if (RESET) begin
         rdata_q  <= cec_pkg::CEC_RDATA_RST;
         rvalid_q <= 1'b0;
         int_q    <= 1'b0;
      end else begin
         rdata_q  <= rdata_d;
         rvalid_q <= rvalid_d;
         int_q    <= int_d;
      end
   end

   assign CSR_RDATA    = rdata_q;
   assign CSR_RVALID   = rvalid_q;
   assign CORR_ERR_INT = int_q;

   default clocking cb @(posedge REF_CLK); endclocking
   default disable iff (RESET);

   icache_once_a:
   assert property (IC_TAG_ERR == 4'hF && IC_DATA_ERR && !wr_sel[0]
                    |=> reg_val[0][26:0] == 27'($past(reg_val[0][26:0])
                                               + 27'h1))
      else $error("cache errors did not count exactly once");

   itcm_both_a:
   assert property (ITCM_FETCH_ERR && ITCM_DMA_ERR && !wr_sel[1]
                    |=> reg_val[1][26:0] == 27'($past(reg_val[1][26:0])
                                               + 27'h2))
      else $error("fetch and DMA errors not both counted");

   dtcm_spec_a:
   assert property (DTCM_LS_SPEC && !DTCM_DMA_ERR && !wr_sel[2]
                    |=> $stable(reg_val[2]))
      else $error("speculative access was counted");

   read_data_a:
   assert property (CSR_RD_EN && !CSR_WR_EN && CSR_ADDR == 12'h7F1
                    |=> CSR_RVALID && CSR_RDATA == $past(reg_val[1]))
      else $error("read of second register returned wrong data");

   unmapped_zero_a:
   assert property (CSR_RD_EN && CSR_ADDR != 12'h7F0
                    && CSR_ADDR != 12'h7F1 && CSR_ADDR != 12'h7F2
                    |=> CSR_RDATA == 32'h0)
      else $error("unmapped read not zero");

   int_follow_a:
   assert property (##1 CORR_ERR_INT == $past(|pending))
      else $error("interrupt does not follow pending state");

   // A firmware reset of the count must end that channel's condition,
   // since the write wins over any error of the same cycle
   int_clear_a:
   assert property (wr_sel[2] && CSR_WDATA[26:0] == 27'h0
                    |=> !pending[2])
      else $error("pending stayed after count cleared");

   // Any pending channel reaches the pin one cycle later
   int_set_a:
   assert property (|pending |=> CORR_ERR_INT)
      else $error("pending channel did not raise interrupt");

   // A lone fetched-instruction error steps the cache count by one
   icache_single_a:
   assert property (IC_DATA_ERR && !wr_sel[0]
                    |=> reg_val[0][26:0] == 27'($past(reg_val[0][26:0])
                                               + 27'h1))
      else $error("cache error not counted");

   // A lone fetch error steps the instruction memory count by one
   itcm_fetch_a:
   assert property (ITCM_FETCH_ERR && !ITCM_DMA_ERR && !wr_sel[1]
                    |=> reg_val[1][26:0] == 27'($past(reg_val[1][26:0])
                                               + 27'h1))
      else $error("fetch error not counted");

   // A qualified load/store error steps the data memory count by one
   dtcm_retire_a:
   assert property (dtcm_ls_ok && !DTCM_DMA_ERR && !wr_sel[2]
                    |=> reg_val[2][26:0] == 27'($past(reg_val[2][26:0])
                                               + 27'h1))
      else $error("retired access error not counted");

   // DMA errors are never gated, whatever the core is doing
   dtcm_dma_a:
   assert property (DTCM_DMA_ERR && !DTCM_LS_ERR && !wr_sel[2]
                    |=> reg_val[2][26:0] == 27'($past(reg_val[2][26:0])
                                               + 27'h1))
      else $error("DMA error not counted");

   // A write replaces the count even when an error lands with it
   write_wins_a:
   assert property (wr_sel[0]
                    |=> reg_val[0][26:0] == $past(CSR_WDATA[26:0]))
      else $error("write lost against same-cycle error");

   // Read valid follows the request by one cycle and never rises without one
   rvalid_pulse_a:
   assert property (!CSR_RD_EN |=> !CSR_RVALID)
      else $error("read valid without request");
endmodule : cec_top

// *** dv/cec_err_src.sv ***
// Model of the memory error detectors feeding the counter bank
module cec_err_src (
   input  wire logic [11:0] req,
   output logic      [3:0]  ic_tag,
   output logic             ic_data,
   output logic             itcm_fetch,
   output logic             itcm_dma,
   output logic             ls_err,
   output logic             ls_retire,
   output logic             ls_spec,
   output logic             ls_exc,
   output logic             dtcm_dma
);
   timeunit 1ns;
   timeprecision 1ns;
   // Each request bit is one detector flag; all may fire together
   assign {ic_tag, ic_data, itcm_fetch, itcm_dma} = req[11:5];
   assign {ls_err, ls_retire, ls_spec, ls_exc, dtcm_dma} = req[4:0];
endmodule : cec_err_src

// *** dv/cec_top_tb.sv ***
// Self-checking bench for the correctable error counter bank
module cec_top_tb;
   timeunit 1ns;
   timeprecision 100ps;
`define CHK(a, b) begin checked++; if ((a) !== (b)) begin fail_count++; \
 $display("MISMATCH t=%0t got=%h exp=%h", $time, a, b); end end
   logic        clk = 1'b0, rst = 1'b1, rd_en = 1'b0, wr_en = 1'b0;
   logic [11:0] addr = '0, req = '0;
   logic [31:0] wdata = '0, rdata;
   logic        rvalid, irq, ld, fe, dm, le, lr, ls, lx, dd;
   logic [3:0]  tg;
   int          fail_count = 0, checked = 0, cycles = 0;
   localparam logic [11:0] AI = cec_pkg::CEC_ADDR_ICACHE;
   localparam logic [11:0] AT = cec_pkg::CEC_ADDR_ITCM;
   localparam logic [11:0] AD = cec_pkg::CEC_ADDR_DTCM;
   // Selector 26 keeps the interrupt quiet for small counts
   localparam logic [31:0] B26 = 32'hD0000000;
   cec_top i_cec_top (.REF_CLK(clk), .RESET(rst), .CSR_RD_EN(rd_en),
      .CSR_WR_EN(wr_en), .CSR_ADDR(addr), .CSR_WDATA(wdata),
      .CSR_RDATA(rdata), .CSR_RVALID(rvalid), .IC_TAG_ERR(tg),
      .IC_DATA_ERR(ld), .ITCM_FETCH_ERR(fe), .ITCM_DMA_ERR(dm),
      .DTCM_LS_ERR(le), .DTCM_LS_RETIRE(lr), .DTCM_LS_SPEC(ls),
      .DTCM_LS_EXC(lx), .DTCM_DMA_ERR(dd), .CORR_ERR_INT(irq));
   cec_err_src i_cec_err_src (.req(req), .ic_tag(tg), .ic_data(ld),
      .itcm_fetch(fe), .itcm_dma(dm), .ls_err(le), .ls_retire(lr),
      .ls_spec(ls), .ls_exc(lx), .dtcm_dma(dd));
   // 40 MHz clock
   initial begin
      forever #12.5 clk = ~clk;
   end
   // Hang guard, far beyond the hundred or so cycles the tests need
   always @(posedge clk) begin
      cycles++;
      if (cycles == 3000) begin
         fail_count++;
         test_done();
      end
   end
   // One register write, request held over a single edge; an idle edge
   // follows so back-to-back calls never retoggle a strobe in one step
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      addr = a; wdata = d; wr_en = 1'b1;
      @(posedge clk) #1;
      wr_en = 1'b0;
      @(posedge clk) #1;
   endtask : wr
   // Read and compare; data answers one cycle after the request
   task automatic rdchk(input logic [11:0] a, input logic [31:0] e);
      addr = a; rd_en = 1'b1;
      @(posedge clk) #1;
      rd_en = 1'b0;
      `CHK(rvalid, 1'b1)
      `CHK(rdata, e)
      @(posedge clk) #1;
   endtask : rdchk
   // One cycle of detector flags
   task automatic err(input logic [11:0] p);
      req = p;
      @(posedge clk) #1;
      req = '0;
      @(posedge clk) #1;
   endtask : err
   task automatic clr();
      wr(AI, B26); wr(AT, B26); wr(AD, B26);
      repeat (2) @(posedge clk) #1;
   endtask : clr
   task automatic t_reset();
      rdchk(AI, 32'h0); rdchk(AT, 32'h0); rdchk(AD, 32'h0);
      rdchk(12'h7F3, 32'h0);
      `CHK(irq, 1'b0)
      $display("reset test done");
   endtask : t_reset
   task automatic t_icache();
      err(12'hF00); rdchk(AI, 32'h1);
      err(12'h080); rdchk(AI, 32'h2);
      err(12'hF80); rdchk(AI, 32'h3);
      `CHK(irq, 1'b1)
      clr(); `CHK(irq, 1'b0)
      $display("cache test done");
   endtask : t_icache
   task automatic t_tcm();
      err(12'h060); rdchk(AT, B26 | 32'h2);
      err(12'h020); rdchk(AT, B26 | 32'h3);
      // Only a retired, committed, fault-free access counts
      for (int q = 0; q < 8; q++) err(12'h010 | 12'(q << 1));
      err(12'h001); rdchk(AD, B26 | 32'h2);
      $display("tcm test done");
   endtask : t_tcm
   task automatic t_clamp();
      logic [4:0] s[3] = '{5'd26, 5'd27, 5'd31};
      foreach (s[i]) begin
         wr(AD, {s[i], 27'h5});
         rdchk(AD, B26 | 32'h5);
         rdchk(AD, B26 | 32'h5);
      end
      $display("clamp test done");
   endtask : t_clamp
   task automatic t_thresh();
      wr(AD, {5'd2, 27'h3}); @(posedge clk) #1;
      `CHK(irq, 1'b0)
      req = 12'h001;
      @(posedge clk) #1;
      req = '0;
      `CHK(irq, 1'b0)
      @(posedge clk) #1; `CHK(irq, 1'b1)
      err(12'h001); @(posedge clk) #1; `CHK(irq, 1'b1)
      wr(AD, {5'd2, 27'h0}); @(posedge clk) #1;
      `CHK(irq, 1'b0)
      $display("threshold test done");
   endtask : t_thresh
   task automatic t_wrap();
      wr(AT, {5'd26, 27'h7FFFFFF}); @(posedge clk) #1;
      `CHK(irq, 1'b1)
      err(12'h040); rdchk(AT, B26);
      `CHK(irq, 1'b0)
      $display("wrap test done");
   endtask : t_wrap
   task automatic test_done();
      $display("checked=%0d fail_count=%0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : test_done
   // Main sequence
   initial begin
      repeat (20) @(posedge clk);
      #1 rst = 1'b0;
      t_reset(); t_icache(); t_tcm(); t_clamp(); t_thresh(); t_wrap();
      test_done();
   end
endmodule : cec_top_tb
